// file: bench/alrt_host.sv
/* host model driving the register port of the alert register bank.
   assumes the block samples its strobes on the rising edge of clk. */
`timescale 1ns/1ps
module alrt_host (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
////////////////////////////////////////////////////////////////////////
    // idle lines start low
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // released lines are inverted so stale values never match
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    // data is taken after the edge that accepted the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : alrt_host

// file: bench/tb_alrt_regs.sv
/* self-checking bench for the alert register bank.
   assumes alrt_pkg is compiled first and the host model drives the port. */
`timescale 1ns/1ps
module tb_alrt_regs;
    import alrt_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_write = 1'b0;
    logic cfg_powerdown = 1'b0;
    logic meas_valid = 1'b0;
    logic meas_overflow = 1'b0;
    logic [15:0] meas_current = 16'h0000;
    logic [15:0] meas_bus_volt = 16'h0000;
    logic [15:0] meas_power = 16'h0000;
    logic [15:0] reg_rdata, reg_wdata, v;
    logic [7:0] reg_addr;
    logic reg_wr, reg_rd, alert_out, alert_oe;
    int fail_count = 0;
    int n_checks = 0;
////////////////////////////////////////////////////////////////////////
    always #4 clk = ~clk;
    alrt_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    alrt_regs uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cfg_write(cfg_write), .cfg_powerdown(cfg_powerdown), .meas_valid(meas_valid),
        .meas_overflow(meas_overflow), .meas_current(meas_current),
        .meas_bus_volt(meas_bus_volt), .meas_power(meas_power),
        .alert_out(alert_out), .alert_oe(alert_oe));
    // compare helpers
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk16
    task automatic chk1(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : chk1
    // one conversion result; the registered pins update on the edge that samples meas_valid
    task automatic meas(input logic o, input logic [15:0] c, b, p);
        @(posedge clk);
        #1;
        meas_valid = 1'b1;
        meas_overflow = o;
        meas_current = c;
        meas_bus_volt = b;
        meas_power = p;
        @(posedge clk);
        #1;
        meas_valid = 1'b0;
    endtask : meas
    task automatic cfg(input logic pd);
        @(posedge clk);
        #1;
        cfg_write = 1'b1;
        cfg_powerdown = pd;
        @(posedge clk);
        #1;
        cfg_write = 1'b0;
        @(posedge clk);
        #1;
    endtask : cfg
////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk1("idle pin", 1'b0, alert_oe);
        host.rd(ALRT_OFS_SELECT, v);
        chk16("select rst", ALRT_RST_SELECT, v);
        host.rd(ALRT_OFS_THRESHOLD, v);
        chk16("thr rst", ALRT_RST_THRESHOLD, v);
        host.wr(ALRT_OFS_MAKER, 16'h0000);
        host.rd(ALRT_OFS_MAKER, v);
        chk16("maker", ALRT_MAKER_DEFAULT, v);
        host.wr(ALRT_OFS_DIE, 16'h0000);
        host.rd(ALRT_OFS_DIE, v);
        chk16("die", {ALRT_DEVICE_DEFAULT, ALRT_REV_DEFAULT}, v);
        host.rd(8'h10, v);
        chk16("unmapped", 16'h0000, v);
        host.wr(ALRT_OFS_SELECT, 16'hFFFF);
        host.rd(ALRT_OFS_SELECT, v);
        chk16("select ro", 16'hFC03, v);
        host.wr(ALRT_OFS_THRESHOLD, 16'hA5C3);
        host.rd(ALRT_OFS_THRESHOLD, v);
        chk16("thr rw", 16'hA5C3, v);
    endtask : t_regs
    // each of the five checks trips on its own measurement and clears at equality
    task automatic t_funcs;
        logic [15:0] c, b, p;
        host.wr(ALRT_OFS_THRESHOLD, 16'h0064);
        for (int i = 0; i < 5; i++) begin
            c = (i == 0) ? 16'h0065 : (i == 1) ? 16'h0063 : 16'h0064;
            b = (i == 2) ? 16'h0065 : (i == 3) ? 16'h0063 : 16'h0064;
            p = (i == 4) ? 16'h0065 : 16'h0064;
            host.wr(ALRT_OFS_SELECT, 16'h8000 >> i);
            meas(1'b0, 16'h0064, 16'h0064, 16'h0064);
            chk1("fn equal", 1'b0, alert_oe);
            meas(1'b0, c, b, p);
            chk1("fn trip", 1'b1, alert_oe);
            meas(1'b0, 16'h0064, 16'h0064, 16'h0064);
            chk1("fn clear", 1'b0, alert_oe);
            host.rd(ALRT_OFS_SELECT, v);
            chk16("fn flags", (16'h8000 >> i) | 16'h0008, v);
        end
    endtask : t_funcs
    task automatic t_priority;
        host.wr(ALRT_OFS_SELECT, 16'hA000);
        meas(1'b0, 16'h0065, 16'h0000, 16'h0000);
        chk1("prio hi", 1'b1, alert_oe);
        meas(1'b0, 16'h0000, 16'h0200, 16'h0000);
        chk1("prio lo", 1'b0, alert_oe);
        host.wr(ALRT_OFS_THRESHOLD, 16'h0000);
        host.wr(ALRT_OFS_SELECT, 16'h4000);
        meas(1'b0, 16'hFFFB, 16'h0000, 16'h0000);
        chk1("signed", 1'b1, alert_oe);
    endtask : t_priority
    task automatic t_latch;
        host.wr(ALRT_OFS_THRESHOLD, 16'h0064);
        host.wr(ALRT_OFS_SELECT, 16'h2001);
        meas(1'b0, 16'h0000, 16'h0065, 16'h0000);
        meas(1'b0, 16'h0000, 16'h0000, 16'h0000);
        chk1("latch hold", 1'b1, alert_oe);
        host.rd(ALRT_OFS_SELECT, v);
        chk16("latch flags", 16'h2019, v);
        @(posedge clk);
        #1;
        chk1("latch clr", 1'b0, alert_oe);
    endtask : t_latch
    task automatic t_polarity;
        host.wr(ALRT_OFS_SELECT, 16'h2002);
        @(posedge clk);
        #1;
        chk1("inv idle", 1'b1, alert_oe);
        meas(1'b0, 16'h0000, 16'h0065, 16'h0000);
        chk1("inv act", 1'b0, alert_oe);
        chk1("pin data", 1'b0, alert_out);
        meas(1'b0, 16'h0000, 16'h0000, 16'h0000);
        chk1("inv clr", 1'b1, alert_oe);
    endtask : t_polarity
    task automatic t_done;
        host.wr(ALRT_OFS_SELECT, 16'h0400);
        host.rd(ALRT_OFS_SELECT, v);
        chk16("done flag", 16'h0408, v);
        @(posedge clk);
        #1;
        chk1("done rd clr", 1'b0, alert_oe);
        meas(1'b0, 16'h0000, 16'h0000, 16'h0000);
        chk1("done pin", 1'b1, alert_oe);
        cfg(1'b1);
        chk1("done pd", 1'b1, alert_oe);
        cfg(1'b0);
        chk1("done cfg", 1'b0, alert_oe);
    endtask : t_done
    task automatic t_ovf;
        host.wr(ALRT_OFS_SELECT, 16'h0000);
        host.rd(ALRT_OFS_SELECT, v);
        meas(1'b1, 16'h0000, 16'h0000, 16'h0000);
        host.rd(ALRT_OFS_SELECT, v);
        chk16("ovf set", 16'h000C, v);
        host.rd(ALRT_OFS_SELECT, v);
        chk16("ovf clr", 16'h0000, v);
    endtask : t_ovf
////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // the whole run needs under two hundred cycles; this is generous
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_regs();
        t_funcs();
        t_priority();
        t_latch();
        t_polarity();
        t_done();
        t_ovf();
        wrap_up();
    end
endmodule : tb_alrt_regs

// file: verilog/alrt_pkg.sv
/*
 * Constants for the alert control and identification register bank:
 * register offsets, field positions, reset values and limit-check codes.
 * Assumes an 8-bit register pointer port driven by the serial front end.
 */
package alrt_pkg;

    // register offsets (8-bit pointer)
    localparam logic [7:0] ALRT_OFS_SELECT = 8'h06;
    localparam logic [7:0] ALRT_OFS_THRESHOLD = 8'h07;
    localparam logic [7:0] ALRT_OFS_MAKER = 8'hFE;
    localparam logic [7:0] ALRT_OFS_DIE = 8'hFF;

    // select/flags register field positions
    localparam int ALRT_BIT_OVERCURRENT = 15;
    localparam int ALRT_BIT_UNDERCURRENT = 14;
    localparam int ALRT_BIT_BUS_OVER = 13;
    localparam int ALRT_BIT_BUS_UNDER = 12;
    localparam int ALRT_BIT_POWER_OVER = 11;
    localparam int ALRT_BIT_DONE_ENABLE = 10;
    localparam int ALRT_BIT_HIT_FLAG = 4;
    localparam int ALRT_BIT_DONE_FLAG = 3;
    localparam int ALRT_BIT_OVERFLOW = 2;
    localparam int ALRT_BIT_POLARITY = 1;
    localparam int ALRT_BIT_LATCH = 0;

    // die code layout
    localparam int ALRT_DEVICE_MSB = 15;
    localparam int ALRT_DEVICE_LSB = 4;
    localparam int ALRT_REV_MSB = 3;

    // reset values
    localparam logic [15:0] ALRT_RST_SELECT = 16'h0000;
    localparam logic [15:0] ALRT_RST_THRESHOLD = 16'h0000;

    // arbitrary neutral identity values, not those of any real part
    localparam logic [15:0] ALRT_MAKER_DEFAULT = 16'h1A2B;
    localparam logic [11:0] ALRT_DEVICE_DEFAULT = 12'h3C4;
    localparam logic [3:0] ALRT_REV_DEFAULT = 4'h1;

    // selected limit check, one-hot
    typedef enum logic [5:0] {
        ALRT_FN_NONE = 6'b000001,
        ALRT_FN_OVERCURRENT = 6'b000010,
        ALRT_FN_UNDERCURRENT = 6'b000100,
        ALRT_FN_BUS_OVER = 6'b001000,
        ALRT_FN_BUS_UNDER = 6'b010000,
        ALRT_FN_POWER_OVER = 6'b100000
    } alrt_fn_t;

endpackage : alrt_pkg

// file: verilog/alrt_regs.sv
/*
 * Alert control and identification registers of a current, voltage and
 * power monitor: selection/flags, threshold, maker and die codes, the
 * limit comparison and the open-collector alert pin.
 * Assumes the serial front end and the measurement path share clk and
 * present single-cycle strobes; the alert pin is pulled up externally.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - overflow flag sets when arithmetic overflows
// - polarity bit picks low or high active
// - latch bit picks transparent or latched alert
// - transparent alert follows the fault going away
// - latched alert holds until select register read
// - threshold compared with selected measurement
// - threshold uses selected measurement's number format
// - threshold is 16-bit read/write, resets zero
// - read-only 16-bit maker code
// - die code: device upper, revision lower
// - one of five checks, plus done notification
// - marginal fault alerts within two conversions
// - large faults may alert sooner
// - highest enabled check bit wins
// - hit flag clear depends on latch mode
// - done flag set/clear conditions
// - done enable drives alert on done flag
module alrt_regs #(
    parameter logic [15:0] MAKER_CODE = alrt_pkg::ALRT_MAKER_DEFAULT,
    parameter logic [11:0] DEVICE_CODE = alrt_pkg::ALRT_DEVICE_DEFAULT,
    parameter logic [3:0] REV_CODE = alrt_pkg::ALRT_REV_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port from the serial front end
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // configuration register events
    input wire logic cfg_write,
    input wire logic cfg_powerdown,
    // measurement path, results valid on meas_valid
    input wire logic meas_valid,
    input wire logic meas_overflow,
    input wire logic [15:0] meas_current,
    input wire logic [15:0] meas_bus_volt,
    input wire logic [15:0] meas_power,
    // open-collector alert pin, output always low
    output logic alert_out,
    output logic alert_oe
);
    import alrt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // signed compare for current, unsigned for voltage and power
    function automatic logic above(input logic [15:0] a, input logic [15:0] b,
                                   input logic signed_fmt);
        if (signed_fmt) begin
            above = $signed(a) > $signed(b);
        end else begin
            above = a > b;
        end
    endfunction : above

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [5:0] check_enable;
    logic done_enable;
    logic polarity;
    logic latch_mode;
    logic hit_flag;
    logic done_flag;
    logic overflow_flag;
    logic [15:0] threshold;
    logic alert_level;

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire sel_access = reg_addr == ALRT_OFS_SELECT;
    wire select_wr = reg_wr && sel_access;
    wire select_rd = reg_rd && sel_access;
    wire threshold_wr = reg_wr && reg_addr == ALRT_OFS_THRESHOLD;
    // power-down selection leaves the done flag alone
    wire done_clear = (cfg_write && !cfg_powerdown) || select_rd;

    // highest enabled check wins
    alrt_fn_t fn_sel;
    assign fn_sel = check_enable[5] ? ALRT_FN_OVERCURRENT :
                    check_enable[4] ? ALRT_FN_UNDERCURRENT :
                    check_enable[3] ? ALRT_FN_BUS_OVER :
                    check_enable[2] ? ALRT_FN_BUS_UNDER :
                    check_enable[1] ? ALRT_FN_POWER_OVER : ALRT_FN_NONE;

    // threshold read in the selected measurement's own format
    logic limit_hit;
    always_comb begin
        case (fn_sel)
            ALRT_FN_OVERCURRENT: limit_hit = above(meas_current, threshold, 1'b1);
            ALRT_FN_UNDERCURRENT: limit_hit = above(threshold, meas_current, 1'b1);
            ALRT_FN_BUS_OVER: limit_hit = above(meas_bus_volt, threshold, 1'b0);
            ALRT_FN_BUS_UNDER: limit_hit = above(threshold, meas_bus_volt, 1'b0);
            ALRT_FN_POWER_OVER: limit_hit = above(meas_power, threshold, 1'b0);
            default: limit_hit = 1'b0;
        endcase
    end

    // next flag values; a setting event beats a read clear
    wire next_hit = meas_valid ? (latch_mode ? (limit_hit || (hit_flag && !select_rd))
                                             : limit_hit)
                               : (hit_flag && !(latch_mode && select_rd));
    wire next_done = meas_valid || (done_flag && !done_clear);
    wire next_overflow = (meas_valid && meas_overflow) || (overflow_flag && !select_rd);
    wire next_level = next_hit || (done_enable && next_done);

    wire [15:0] select_word = {check_enable[5:1], done_enable, 5'h00, hit_flag, done_flag,
                               overflow_flag, polarity, latch_mode};
    wire [15:0] die_word = {DEVICE_CODE, REV_CODE};

    logic [15:0] next_rdata;
    always_comb begin
        case (reg_addr)
            ALRT_OFS_SELECT: next_rdata = select_word;
            ALRT_OFS_THRESHOLD: next_rdata = threshold;
            ALRT_OFS_MAKER: next_rdata = MAKER_CODE;
            ALRT_OFS_DIE: next_rdata = die_word;
            default: next_rdata = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers written by the host

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            check_enable <= ALRT_RST_SELECT[ALRT_BIT_OVERCURRENT:ALRT_BIT_DONE_ENABLE];
            polarity <= ALRT_RST_SELECT[ALRT_BIT_POLARITY];
            latch_mode <= ALRT_RST_SELECT[ALRT_BIT_LATCH];
        end else if (select_wr) begin
            check_enable <= reg_wdata[ALRT_BIT_OVERCURRENT:ALRT_BIT_DONE_ENABLE];
            polarity <= reg_wdata[ALRT_BIT_POLARITY];
            latch_mode <= reg_wdata[ALRT_BIT_LATCH];
        end
    end
    assign done_enable = check_enable[0];

    // threshold register
    // limitation: no format check; the host loads it in the selected format
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            threshold <= ALRT_RST_THRESHOLD;
        end else if (threshold_wr) begin
            threshold <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags; evaluated once per conversion, so alert lands one cycle after
    // the result the measurement path hands over, whatever its averaging
    // hazard: a result and a clearing read in one cycle; the set wins

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hit_flag <= 1'b0;
            done_flag <= 1'b0;
            overflow_flag <= 1'b0;
            alert_level <= 1'b0;
        end else begin
            hit_flag <= next_hit;
            done_flag <= next_done;
            overflow_flag <= next_overflow;
            alert_level <= next_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and pin; read data latched on the strobe, so it holds the
    // flags as they stood before the same edge cleared them

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // open collector: pin pulled low while the enable is high
    // never driven high, so the external pull-up gives the released level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alert_oe <= 1'b0;
            alert_out <= 1'b0;
        end else begin
            alert_oe <= next_level ^ polarity;
            alert_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_overflow_set: assert property (
        meas_valid && meas_overflow |=> overflow_flag ##1 (overflow_flag || $past(select_rd)))
        else $error("overflow flag not set after overflow");

    chk_pin_polarity: assert property (
        !$past(select_wr) |-> alert_oe == (alert_level ^ polarity))
        else $error("alert pin level disagrees with polarity");

    chk_latch_hold: assert property (
        latch_mode && hit_flag && !select_rd && !select_wr |=> hit_flag)
        else $error("latched hit flag dropped without a read");

    chk_transparent_clear: assert property (
        !latch_mode && meas_valid && !limit_hit && !select_wr
        |=> !hit_flag && alert_level == done_enable)
        else $error("transparent alert stayed after fault cleared");

    chk_done_clear: assert property (
        done_clear && !meas_valid |=> !done_flag)
        else $error("done flag not cleared");

    chk_read_capture: assert property (
        select_rd |=> reg_rdata[ALRT_BIT_HIT_FLAG] == $past(hit_flag)
                      && reg_rdata[ALRT_BIT_DONE_FLAG] == $past(done_flag))
        else $error("select read lost a flag");

    chk_id_read: assert property (
        reg_rd && reg_addr == ALRT_OFS_MAKER |=> reg_rdata == MAKER_CODE)
        else $error("maker code read wrong");

    chk_alert_fast: assert property (
        meas_valid && limit_hit && !select_wr |=> alert_level && hit_flag)
        else $error("alert late after limit hit");

    chk_priority_pick: assert property (
        check_enable[5] |-> limit_hit == ($signed(meas_current) > $signed(threshold)))
        else $error("priority of checks wrong");

    chk_done_alert: assert property (
        done_enable && done_flag && !$past(select_wr) |-> alert_level)
        else $error("done notification missed on alert");

    ////////////////////////////////////////////////////////////////////////
    // register, field and compare checks; the compare checks pin the undercurrent,
    // bus-over and power checks to their own measurement and number format

    chk_latch_select: assert property (
        select_wr && reg_wdata[ALRT_BIT_LATCH] |=> latch_mode)
        else $error("latch select not taken");

    chk_polarity_select: assert property (
        select_wr && reg_wdata[ALRT_BIT_POLARITY] |=> polarity)
        else $error("polarity select not taken");

    chk_threshold_write: assert property (
        threshold_wr |=> threshold == $past(reg_wdata))
        else $error("threshold write lost");

    chk_threshold_hold: assert property (
        !threshold_wr |=> $stable(threshold))
        else $error("threshold changed without a write");

    chk_die_read: assert property (
        reg_rd && reg_addr == ALRT_OFS_DIE
        |=> reg_rdata[ALRT_DEVICE_MSB:ALRT_DEVICE_LSB] == DEVICE_CODE
            && reg_rdata[ALRT_REV_MSB:0] == REV_CODE)
        else $error("die code read wrong");

    chk_no_check: assert property (
        check_enable[5:1] == 5'h00 |-> !limit_hit)
        else $error("limit hit with no check enabled");

    chk_under_compare: assert property (
        fn_sel == ALRT_FN_UNDERCURRENT |-> limit_hit == ($signed(threshold) > $signed(meas_current)))
        else $error("undercurrent compare wrong");

    chk_bus_compare: assert property (
        fn_sel == ALRT_FN_BUS_OVER |-> limit_hit == (meas_bus_volt > threshold))
        else $error("bus voltage compare wrong");

    chk_power_compare: assert property (
        fn_sel == ALRT_FN_POWER_OVER |-> limit_hit == (meas_power > threshold))
        else $error("power compare wrong");

    chk_hit_read_clear: assert property (
        latch_mode && select_rd && !meas_valid |=> !hit_flag)
        else $error("latched hit flag kept after read");

    chk_done_set: assert property (
        meas_valid |=> done_flag)
        else $error("done flag not set after result");

    chk_overflow_clear: assert property (
        select_rd && !meas_valid |=> !overflow_flag)
        else $error("overflow flag kept after read");

endmodule : alrt_regs
